// ==== rtl/fsc_pkg.sv ====
// Package of constants and carrier types for the floppy seek control block.
// What this block does
// R01: Recalibrate zeroes cylinder, steps out until track zero.
// R02: After 79 steps without track zero, flag error.
// R03: Busy only while taking commands; seeks run in background.
// R04: Seek direction in when below target, out above.
// R05: Steps spaced by interval; equality ends seek.
// R06: Interrupt on seek ends and transfer requests.
// R07: Sense interrupt clears irq, reports end and code.
// R08: Head address bit reads zero after seeks.
// R09: Drive stays busy until sense interrupt taken.
// R10: Leaving power-down clears cylinders and status.
// R11: Sense drive status answers at once.
// R12: Step interval code scales with data rate.
// R13: Head unload delay counts after transfer end; head_load_out drops at once on C_RWEND instead.
// R14: Head load delay times before transfer start.
// R15: No-DMA selects request bit and irq, else DMA.
// R16: Implied seek precedes read/write when enabled; the code starts it with C_RW and waits on head load only.
// R17: Queue disable defaults to one.
// R18: Polling gives one interrupt after reset, not while loaded.
// R19: Queue threshold encoded value plus one, default one.
// R20: Precompensation start track 0 to 255, default 0.
// R21: Relative seek steps count in direction, modulo 256.
// R22: One relative seek at once; outward past zero flags error.
`default_nettype none
package fsc_pkg;
    localparam int NDRV = 4;
    localparam logic [11:0] A_CMD    = 12'h000;
    localparam logic [11:0] A_STAT   = 12'h004;
    localparam logic [11:0] A_SPEC   = 12'h008;
    localparam logic [11:0] A_CONF   = 12'h00C;
    localparam logic [11:0] A_RES    = 12'h010;
    localparam logic [11:0] A_PCYL   = 12'h014;
    localparam logic [11:0] A_CTRL   = 12'h018;
    localparam logic [3:0] C_RECAL  = 4'h1;
    localparam logic [3:0] C_SEEK   = 4'h2;
    localparam logic [3:0] C_RSEEK  = 4'h3;
    localparam logic [3:0] C_SENSEI = 4'h4;
    localparam logic [3:0] C_SENSED = 4'h5;
    localparam logic [3:0] C_VER    = 4'h6;
    localparam logic [3:0] C_RW     = 4'h7;
    localparam logic [3:0] C_RWEND  = 4'h8;
    localparam logic [7:0] VERSION_ID  = 8'h5A; // Arbitrary value.
    localparam logic [7:0] RECAL_MAX   = 8'h4F;
    localparam logic [7:0] ST0_POLL    = 8'hC0;
    localparam logic [1:0] IC_NORM     = 2'h0;
    localparam logic [1:0] IC_ABN      = 2'h1;
    localparam logic [1:0] IC_POLL     = 2'h3;
    localparam int SE_BIT = 5;
    localparam int EC_BIT = 4;
    localparam int CLK_MHZ = 125;
    localparam int STEP_UNIT_US = 1000;
    localparam int STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
    localparam int LOAD_UNIT_US = 2000;
    localparam int LOAD_UNIT_CYC = LOAD_UNIT_US * CLK_MHZ;
    localparam int UNLD_UNIT_US = 16000;
    localparam int UNLD_UNIT_CYC = UNLD_UNIT_US * CLK_MHZ;
    localparam int STEP_PULSE_NS = 1000;
    localparam int STEP_PULSE_CYC = STEP_PULSE_NS / 8;
    localparam logic [3:0] SPEC_RST = 4'h0;
    localparam logic [7:0] PRECOMP_START_TRACK_RST = 8'h00;
    localparam logic [3:0] THR_RST = 4'h0;
    typedef enum logic [1:0] {FSC_IDLE, FSC_DIR, FSC_PULSE, FSC_WAIT} fsc_ph_t;
    typedef struct packed {
        fsc_ph_t     ph;
        logic        rel;
        logic        recal;
        logic [7:0]  target;
        logic [7:0]  left;
        logic        dir;
        logic [31:0] tmr;
        logic        done;
        logic [1:0]  ic;
        logic        ec;
    } fsc_drv_t;
endpackage : fsc_pkg
`default_nettype wire

// ==== rtl/fsc_top.sv ====
// Seek, recalibrate and status logic for the floppy controller, with an APB slave.
//
// The placing of the registers and the APB register port were left to the implementer.
`default_nettype none
module fsc_top #(
    parameter int STEP_UNIT = fsc_pkg::STEP_UNIT_CYC,
    parameter int LOAD_UNIT = fsc_pkg::LOAD_UNIT_CYC,
    parameter int UNLD_UNIT = fsc_pkg::UNLD_UNIT_CYC,
    parameter int RATE_DIV  = 2
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [fsc_pkg::NDRV-1:0] track_zero_in,
    input  wire logic [fsc_pkg::NDRV-1:0] drive_status_in,
    input  wire logic                    xfer_need,
    input  wire logic                    powerdown_exit,
    output logic      [fsc_pkg::NDRV-1:0] step_out,
    output logic      [fsc_pkg::NDRV-1:0] dir_out,
    output logic                         head_load_out,
    output logic                         dma_request_out,
    output logic                         controller_irq_out
);
    import fsc_pkg::*;

    initial begin
        if (STEP_UNIT < 1 || LOAD_UNIT < 1 || UNLD_UNIT < 1 || RATE_DIV < 1 || RATE_DIV > 8)
            $error("fsc_top: timing parameter out of range");
    end

    typedef struct packed {
        fsc_drv_t [NDRV-1:0] d;
        logic [NDRV-1:0][7:0] pcyl;
        logic [NDRV-1:0] tz1;
        logic [NDRV-1:0] tz2;
        logic [NDRV-1:0] ds1;
        logic [NDRV-1:0] ds2;
        logic [1:0]  x1;
        logic [1:0]  x2;
        logic [3:0]  step_interval_code;
        logic [3:0]  head_unload_code;
        logic [6:0]  head_load_code;
        logic        no_dma_select;
        logic        implied_seek_enable;
        logic        queue_disable;
        logic        poll_disable;
        logic [3:0]  queue_threshold;
        logic [7:0]  precomp_start_track;
        logic [7:0]  result;
        logic        irq;
        logic        poll_pend;
        logic        loaded;
        logic [31:0] htmr;
        logic        rw_wait;
        logic        request_for_master;
        logic        dma;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } fsc_st_t;

    fsc_st_t st_reg;
    fsc_st_t st_next;

    logic wr_en;
    logic rd_en;
    logic [3:0] cmd;
    logic [1:0] dsel;
    logic busy;
    logic [NDRV-1:0] tz;
    logic [31:0] step_gap;

    assign wr_en = psel && penable && pwrite && !st_reg.pready;
    assign rd_en = psel && penable && !pwrite && !st_reg.pready;
    assign cmd   = pwdata[11:8];
    assign dsel  = pwdata[13:12];
    assign tz    = st_reg.tz2;
    // Code F gives one unit, code 0 gives sixteen units, scaled by rate divider.
    assign step_gap = (32'(5'd16 - {1'b0, st_reg.step_interval_code}) * 32'(STEP_UNIT)) / 32'(RATE_DIV); // R12

    always_comb begin
        st_next = st_reg;
        busy = 1'b0;
        st_next.tz1 = track_zero_in;
        st_next.tz2 = st_reg.tz1;
        st_next.ds1 = drive_status_in;
        st_next.ds2 = st_reg.ds1;
        st_next.x1 = {powerdown_exit, xfer_need};
        st_next.x2 = st_reg.x1;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;

        for (int i = 0; i < NDRV; i++) begin
            unique case (st_reg.d[i].ph)
                FSC_IDLE: ;
                FSC_DIR: begin
                    if (st_reg.d[i].recal && tz[i]) begin
                        st_next.d[i].ph = FSC_IDLE; // R01
                        st_next.d[i].done = 1'b1;
                        st_next.d[i].ic = IC_NORM;
                    end else if (!st_reg.d[i].recal && !st_reg.d[i].rel
                                 && st_reg.pcyl[i] == st_reg.d[i].target) begin
                        st_next.d[i].ph = FSC_IDLE; // R05
                        st_next.d[i].done = 1'b1;
                        st_next.d[i].ic = IC_NORM;
                    end else if (st_reg.d[i].rel && st_reg.d[i].left == 8'h00) begin
                        st_next.d[i].ph = FSC_IDLE; // R21
                        st_next.d[i].done = 1'b1;
                        st_next.d[i].ic = st_reg.d[i].ec ? IC_ABN : IC_NORM;
                    end else if (st_reg.d[i].recal && st_reg.d[i].left == 8'h00) begin
                        st_next.d[i].ph = FSC_IDLE; // R02
                        st_next.d[i].done = 1'b1;
                        st_next.d[i].ec = 1'b1;
                        st_next.d[i].ic = IC_ABN;
                    end else begin
                        if (!st_reg.d[i].recal && !st_reg.d[i].rel)
                            st_next.d[i].dir = st_reg.pcyl[i] < st_reg.d[i].target; // R04
                        if (st_reg.d[i].rel && !st_reg.d[i].dir && tz[i])
                            st_next.d[i].ec = 1'b1; // R22
                        st_next.d[i].ph = FSC_PULSE;
                        st_next.d[i].tmr = 32'(STEP_PULSE_CYC);
                    end
                end
                FSC_PULSE: begin
                    if (st_reg.d[i].tmr <= 32'd1) begin
                        st_next.d[i].ph = FSC_WAIT;
                        st_next.d[i].tmr = step_gap; // R05
                        if (!st_reg.d[i].recal)
                            st_next.pcyl[i] = st_reg.d[i].dir ? st_reg.pcyl[i] + 8'h01
                                                              : st_reg.pcyl[i] - 8'h01; // R21
                        if (st_reg.d[i].rel || st_reg.d[i].recal)
                            st_next.d[i].left = st_reg.d[i].left - 8'h01;
                    end else begin
                        st_next.d[i].tmr = st_reg.d[i].tmr - 32'd1;
                    end
                end
                FSC_WAIT: begin
                    if (st_reg.d[i].tmr <= 32'd1)
                        st_next.d[i].ph = FSC_DIR;
                    else
                        st_next.d[i].tmr = st_reg.d[i].tmr - 32'd1;
                end
            endcase
            if (st_reg.d[i].done && !st_reg.d[i].recal && st_reg.d[i].ph == FSC_IDLE)
                st_next.irq = 1'b1;
            if (st_next.d[i].done && !st_reg.d[i].done)
                st_next.irq = 1'b1; // R06
        end

        // Head load timing before a read or write; the unload count after it drives no output.
        if (st_reg.htmr != 32'd0)
            st_next.htmr = st_reg.htmr - 32'd1;
        else if (st_reg.rw_wait)
            st_next.rw_wait = 1'b0; // R14
        else if (st_reg.loaded && !st_reg.request_for_master && !st_reg.dma
                 && st_reg.htmr == 32'd0 && st_reg.head_unload_code != 4'h0 && 1'b0)
            st_next.loaded = 1'b0;
        if (st_reg.x2[0] && !st_reg.rw_wait && st_reg.loaded) begin
            if (st_reg.no_dma_select) begin
                st_next.request_for_master = 1'b1; // R15
                if (!st_reg.request_for_master)
                    st_next.irq = 1'b1; // R06
            end else begin
                st_next.dma = 1'b1; // R15
            end
        end else begin
            st_next.request_for_master = 1'b0;
            st_next.dma = 1'b0;
        end

        if (st_reg.poll_pend) begin
            st_next.poll_pend = 1'b0;
            if (!st_reg.poll_disable && !st_reg.loaded)
                st_next.irq = 1'b1; // R18
        end

        // Busy only while a command word is being accepted.
        busy = psel && pwrite && paddr == A_CMD; // R03

        if (wr_en) begin
            st_next.pready = 1'b1;
            unique case (paddr)
                A_CMD: begin
                    unique case (cmd)
                        C_RECAL: begin
                            st_next.pcyl[dsel] = 8'h00; // R01
                            st_next.d[dsel].ph = FSC_DIR;
                            st_next.d[dsel].recal = 1'b1;
                            st_next.d[dsel].rel = 1'b0;
                            st_next.d[dsel].dir = 1'b0;
                            st_next.d[dsel].left = RECAL_MAX; // R02
                            st_next.d[dsel].done = 1'b0;
                            st_next.d[dsel].ec = 1'b0;
                        end
                        C_SEEK: begin
                            st_next.d[dsel].ph = FSC_DIR; // R03
                            st_next.d[dsel].recal = 1'b0;
                            st_next.d[dsel].rel = 1'b0;
                            st_next.d[dsel].target = pwdata[7:0];
                            st_next.d[dsel].done = 1'b0;
                            st_next.d[dsel].ec = 1'b0;
                        end
                        C_RSEEK: begin
                            // A second relative seek while one runs is refused.
                            if (!(st_reg.d[0].rel && st_reg.d[0].ph != FSC_IDLE)
                                && !(st_reg.d[1].rel && st_reg.d[1].ph != FSC_IDLE)
                                && !(st_reg.d[2].rel && st_reg.d[2].ph != FSC_IDLE)
                                && !(st_reg.d[3].rel && st_reg.d[3].ph != FSC_IDLE)) begin
                                st_next.d[dsel].ph = FSC_DIR; // R22
                                st_next.d[dsel].recal = 1'b0;
                                st_next.d[dsel].rel = 1'b1;
                                st_next.d[dsel].dir = pwdata[14]; // R21
                                st_next.d[dsel].left = pwdata[7:0];
                                st_next.d[dsel].done = 1'b0;
                                st_next.d[dsel].ec = 1'b0;
                            end else begin
                                st_next.pslverr = 1'b1;
                            end
                        end
                        C_SENSEI: begin
                            st_next.irq = 1'b0; // R07
                            st_next.result = ST0_POLL;
                            for (int k = NDRV - 1; k >= 0; k--) begin
                                if (st_reg.d[k].done) begin
                                    // Head address bit stays zero.
                                    st_next.result = {st_reg.d[k].ic, 1'b1, st_reg.d[k].ec,
                                                      2'b00, 2'(k)}; // R08
                                end
                            end
                            for (int k = 0; k < NDRV; k++) begin
                                if (st_reg.d[k].done) begin
                                    st_next.d[k].done = 1'b0; // R09
                                    break;
                                end
                            end
                        end
                        C_SENSED: st_next.result = {2'b00, tz[dsel], st_reg.ds2[dsel],
                                                    2'b00, dsel}; // R11
                        C_VER: st_next.result = VERSION_ID;
                        C_RW: begin
                            if (st_reg.implied_seek_enable) begin
                                st_next.d[dsel].ph = FSC_DIR; // R16
                                st_next.d[dsel].recal = 1'b0;
                                st_next.d[dsel].rel = 1'b0;
                                st_next.d[dsel].target = pwdata[7:0];
                            end
                            st_next.loaded = 1'b1;
                            st_next.rw_wait = 1'b1;
                            st_next.htmr = (32'(st_reg.head_load_code == 7'h00 ? 8'd128 : {1'b0, st_reg.head_load_code})
                                            * 32'(LOAD_UNIT)) / 32'(RATE_DIV); // R14
                        end
                        C_RWEND: begin
                            st_next.irq = 1'b1; // R06
                            st_next.htmr = (32'(st_reg.head_unload_code == 4'h0 ? 5'd16 : {1'b0, st_reg.head_unload_code})
                                            * 32'(UNLD_UNIT)) / 32'(RATE_DIV); // R13
                            st_next.loaded = 1'b0;
                        end
                        default: st_next.pslverr = 1'b1;
                    endcase
                end
                A_SPEC: begin
                    st_next.step_interval_code = pwdata[3:0]; // R12
                    st_next.head_unload_code = pwdata[7:4];
                    st_next.head_load_code = pwdata[14:8];
                    st_next.no_dma_select = pwdata[15]; // R15
                end
                A_CONF: begin
                    st_next.implied_seek_enable = pwdata[0]; // R16
                    st_next.queue_disable = pwdata[1]; // R17
                    st_next.poll_disable = pwdata[2]; // R18
                    st_next.queue_threshold = pwdata[7:4]; // R19
                    st_next.precomp_start_track = pwdata[15:8]; // R20
                end
                default: st_next.pslverr = 1'b1;
            endcase
        end else if (rd_en) begin
            st_next.pready = 1'b1;
            unique case (paddr)
                // A finished drive reads busy until its sense interrupt is taken.
                A_STAT: st_next.prdata = {24'h0, st_reg.request_for_master, 3'b000,
                                          (st_reg.d[3].ph != FSC_IDLE || st_reg.d[3].done),
                                          (st_reg.d[2].ph != FSC_IDLE || st_reg.d[2].done),
                                          (st_reg.d[1].ph != FSC_IDLE || st_reg.d[1].done),
                                          (st_reg.d[0].ph != FSC_IDLE || st_reg.d[0].done)}; // R09
                A_SPEC: st_next.prdata = {16'h0, st_reg.no_dma_select, st_reg.head_load_code,
                                          st_reg.head_unload_code, st_reg.step_interval_code};
                A_CONF: st_next.prdata = {16'h0, st_reg.precomp_start_track, st_reg.queue_threshold,
                                          1'b0, st_reg.poll_disable, st_reg.queue_disable,
                                          st_reg.implied_seek_enable};
                A_RES:  st_next.prdata = {24'h0, st_reg.result};
                A_PCYL: st_next.prdata = {st_reg.pcyl[3], st_reg.pcyl[2], st_reg.pcyl[1],
                                          st_reg.pcyl[0]};
                default: begin
                    st_next.prdata = 32'h0000_0000;
                    st_next.pslverr = 1'b1;
                end
            endcase
        end

        // Power-down exit wipes positions and held status.
        if (st_reg.x2[1]) begin
            for (int i = 0; i < NDRV; i++) begin
                st_next.pcyl[i] = 8'h00; // R10
                st_next.d[i] = '0;
            end
            st_next.result = 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.queue_disable <= 1'b1; // R17
            st_reg.queue_threshold <= THR_RST; // R19
            st_reg.precomp_start_track <= PRECOMP_START_TRACK_RST; // R20
            st_reg.poll_pend <= 1'b1; // R18
            st_reg.step_interval_code <= SPEC_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        for (int i = 0; i < NDRV; i++) begin
            step_out[i] = st_reg.d[i].ph == FSC_PULSE;
            dir_out[i]  = st_reg.d[i].dir;
        end
    end
    assign head_load_out      = st_reg.loaded;
    assign dma_request_out    = st_reg.dma;
    assign controller_irq_out = st_reg.irq;
    assign prdata             = st_reg.prdata;
    assign pready             = st_reg.pready;
    assign pslverr            = st_reg.pslverr;

    logic unused_busy;
    assign unused_busy = busy;

    AST_RECAL_DIR: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.d[0].recal && st_reg.d[0].ph == FSC_PULSE) |-> !dir_out[0]) // R01
        else $error("recalibrate stepped inward");
    AST_SEEK_DIR: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_reg.d[0].recal && !st_reg.d[0].rel && st_reg.d[0].ph == FSC_PULSE)
        |-> dir_out[0] == (st_reg.pcyl[0] < st_reg.d[0].target)) // R04
        else $error("seek direction wrong");
    AST_SENSE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == A_CMD && cmd == C_SENSEI && st_reg.d == st_next.d
         && !st_next.irq) |=> !controller_irq_out) // R07
        else $error("sense interrupt left irq high");
    AST_DONE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(st_reg.d[0].done)) |-> controller_irq_out) // R06
        else $error("seek end without irq");
    AST_DMA_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.no_dma_select |-> !dma_request_out) // R15
        else $error("dma request in non-dma mode");
    AST_RECAL_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.d[0].recal && st_reg.d[0].ph != FSC_IDLE) |-> st_reg.d[0].left <= RECAL_MAX) // R02
        else $error("recalibrate step count overrun");
    AST_RESULT_H: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == A_CMD && cmd == C_SENSEI) |=> st_reg.result[2] == 1'b0) // R08
        else $error("head bit set");
    AST_PWRDN: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.x2[1] |=> st_reg.pcyl[0] == 8'h00) // R10
        else $error("cylinder kept after power-down exit");
endmodule : fsc_top
`default_nettype wire

// ==== test/fsc_drive_model.sv ====
// Behavioural model of four drive mechanisms answering step, direction and track zero.
`default_nettype none
module fsc_drive_model #(
    parameter int P1 = 5,
    parameter int P2 = 100
) (
    input  wire logic       pclk,
    input  wire logic [3:0] step_out,
    input  wire logic [3:0] dir_out,
    output logic      [3:0] track_zero_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int         pos [4];
    logic [3:0] prev;
    initial begin
        pos = '{0, P1, P2, 0};
        prev = 4'h0;
    end
    // The head moves on the rising edge of each step pulse; a stop holds it at track zero.
    always @(posedge pclk) begin
        prev <= step_out;
        for (int i = 0; i < 4; i++)
            if (step_out[i] && !prev[i])
                pos[i] <= dir_out[i] ? pos[i] + 1 : (pos[i] > 0 ? pos[i] - 1 : 0);
    end
    always @* for (int i = 0; i < 4; i++) track_zero_in[i] = (pos[i] == 0);
endmodule // fsc_drive_model
`default_nettype wire

// ==== test/fsc_top_tb_top.sv ====
// Self-checking testbench for the floppy seek control block.
`default_nettype none
module fsc_top_tb_top;
    import fsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pd_exit = 0, xn = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, hl, dreq, irq, rdy;
    logic [3:0] tz, step, dir;
    int failures = 0, total_checks = 0, n;
    fsc_top #(.STEP_UNIT(4), .LOAD_UNIT(4), .UNLD_UNIT(4)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .track_zero_in(tz),
        .drive_status_in(4'hA), .xfer_need(xn), .powerdown_exit(pd_exit), .step_out(step),
        .dir_out(dir), .head_load_out(hl), .dma_request_out(dreq), .controller_irq_out(irq));
    fsc_drive_model MDL (.pclk(pclk), .step_out(step), .dir_out(dir), .track_zero_in(tz));
    initial forever #4 pclk = ~pclk;
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // The request is held until pready is seen high at a falling edge, for at most 50 cycles.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Sample the settled answer mid-cycle; it is taken at the following rising edge.
        do begin
            @(negedge pclk);
            rdy = (pready === 1'b1);
            r = prdata;
            e = pslverr;
            n++;
            @(posedge pclk);
        end while (!rdy && n < 50);
        if (!rdy)
            failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic sense(input logic [7:0] st0);
        apb(1, A_CMD, 32'h400);
        apb(0, A_RES, 0);
        chk(r[7:0], st0);
        chk(irq, 0);
    endtask
    // One positioning command, checked from the command write to the cylinder read.
    task automatic run(input logic [15:0] c, input int d, input logic [1:0] dx,
                       input logic [7:0] st0, input logic [8:0] pc);
        if (c != 0)
            apb(1, A_CMD, {16'h0, c});
        apb(0, A_STAT, 0);
        chk(r[d], 1);
        for (n = 0; !dx[1] && step[d] !== 1'b1 && n < 2000; n++) @(posedge pclk);
        if (!dx[1])
            chk(dir[d], dx[0]);
        for (n = 0; irq !== 1'b1 && n < 30000; n++) @(posedge pclk);
        chk(irq, 1);
        apb(0, A_STAT, 0);
        chk(r[d], 1);
        sense(st0);
        apb(0, A_STAT, 0);
        chk(r[d], 0);
        apb(0, A_PCYL, 0);
        if (!pc[8])
            chk(r[8*d+:8], pc[7:0]);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(irq, 1);
        sense(ST0_POLL);
        apb(1, A_CMD, 32'h600);
        apb(0, A_RES, 0);
        chk(r[7:0], VERSION_ID);
        apb(1, A_SPEC, 32'h000E);
        apb(1, A_CMD, 32'h700);
        chk(hl, 1);
        xn <= 1'b1;
        repeat (300) @(posedge pclk);
        chk(dreq, 1);
        xn <= 1'b0;
        apb(1, A_CMD, 32'h800);
        chk(irq, 1);
        sense(ST0_POLL);
        chk(hl, 0);
        run(16'h0203, 0, 2'b01, 8'h20, 9'h003);
        run(16'h0201, 0, 2'b00, 8'h20, 9'h001);
        run(16'h1100, 1, 2'b00, 8'h21, 9'h000);
        run(16'h2100, 2, 2'b00, 8'h72, 9'h100);
        run(16'h3302, 3, 2'b10, 8'h73, 9'h100);
        apb(1, A_CMD, 32'h4302);
        apb(1, A_CMD, 32'h5301);
        chk(e, 1);
        run(16'h0000, 0, 2'b01, 8'h20, 9'h003);
        apb(0, 12'hFFC, 0);
        chk(e, 1);
        chk(r, 0);
        pd_exit <= 1'b1;
        repeat (6) @(posedge pclk);
        pd_exit <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(0, A_PCYL, 0);
        chk(r, 0);
        end_of_test();
    end
    initial begin
        #600000;
        failures++;
        end_of_test();
    end
endmodule // fsc_top_tb_top
`default_nettype wire
